// ### include/hbs_pkg.sv
// Package for the holding brake sequencer: state enum, timing constants, carriers.
// Assumes a 40 MHz system clock and a 1 ms control tick made by the sequencer.
package hbs_pkg;

  // ********************************************************
  // Clock and tick
  // ********************************************************
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;

  // ********************************************************
  // Settings and defaults (times in ms ticks)
  // ********************************************************
  localparam int unsigned TIME_W            = 16;
  localparam int unsigned SPEED_W           = 16;
  localparam logic [1:0]  ENABLE_LOCKED     = 2'h0;
  localparam logic [1:0]  ENABLE_SEQUENCE   = 2'h3;
  localparam int unsigned RELEASE_WAIT_MS   = 100;
  localparam int unsigned CLOSE_WAIT_MS     = 100;
  localparam int unsigned MAGNETIZE_MS      = 0;
  localparam logic [15:0] STANDSTILL_RPM    = 16'h0014;
  localparam int unsigned STATUS_BIT        = 12;
  localparam logic [15:0] SRC_BRAKE_STATUS  = 16'h5212;
  localparam logic [15:0] SRC_START_FREQ    = 16'h1351;
  localparam logic [15:0] SRC_TORQUE_DFLT   = 16'h0000;
  localparam logic [15:0] START_FREQ_DFLT   = 16'h0000;

  typedef enum logic [2:0] {
    HBS_IDLE, HBS_MAGNETIZE, HBS_OPENING, HBS_RUN, HBS_DECEL, HBS_CLOSING
  } hbs_state_e;

  // Stop commands travel together.
  typedef struct packed {
    logic ramp_stop_cmd;
    logic quick_stop_cmd;
    logic coast_stop_cmd;
  } hbs_stop_s;

  // Drive commands toward the motor control.
  typedef struct packed {
    logic energize;
    logic hold_zero;
    logic ramp_up;
    logic decelerate;
    logic slip_comp_on;
  } hbs_drive_s;

endpackage

// ### rtl/hbs_timer.sv
// Down-counter for one sequencer interval.
// Assumes tick_i is a one-cycle pulse on sys_clk_i.
`timescale 1ns/1ps
module hbs_timer #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         arst_n_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  input  wire logic         tick_i,
  // Result
  output logic              expire_o
);

  logic [W-1:0] cnt_q;
  logic         run_q;

  // Load wins over counting; a zero load expires on the next tick.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q    <= '0;
      run_q    <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (load_i) begin
        cnt_q <= value_i;
        run_q <= 1'b1;
      end else if (run_q && tick_i) begin
        if (cnt_q == '0) begin
          run_q    <= 1'b0;
          expire_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end

  chk_expire_one_cycle : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    expire_o |=> !expire_o) else $error("timer expiry lasted more than one cycle");

endmodule

// ### rtl/hbs_sequencer.sv
// Holding brake sequencer: switch-on, stop and forced brake handling.
// Assumes settings are static while running and speed is an absolute rpm value.
// Functional notes
// - On switch-on energize motor, release brake after magnetizing interval.
// - Hold zero speed until release waiting time has elapsed.
// - After release wait expires, ramp toward the speed setpoint.
// - Ramp or quick stop decelerates; below 20 rpm drop release, stay energized.
// - After dropping release on stop, wait closing time, then de-energize.
// - Coast stop drops the release command at once, whatever the speed.
// - Enable 0 locks the brake function; 3 selects sequential control.
// - Release wait defaults to 0.1 s; operator sets above relay plus release.
// - Close wait defaults to 0.1 s; operator sets above relay plus closing.
// - Release command is status bit 12, routed to outputs selecting 52.12.
// - Forced-release input, default 0, opens the brake regardless of sequence.
// - Forced-close input, default 0, closes the brake regardless of sequence.
// - Starting frequency default 0%; above zero enables slip compensation.
// - Start frequency source selector defaults to 1351.
// - Start torque source selector defaults to 0.
`timescale 1ns/1ps
module hbs_sequencer #(
  parameter int unsigned TW = hbs_pkg::TIME_W,
  parameter int unsigned SW = hbs_pkg::SPEED_W,
  parameter int unsigned TN = hbs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 arst_n_i,
  // Commands
  input  wire logic                 switch_on_i,
  input  wire hbs_pkg::hbs_stop_s   stop_i,
  input  wire logic                 forced_brake_release_i,
  input  wire logic                 forced_brake_close_i,
  // Settings
  input  wire logic [1:0]           brake_function_enable_i,
  input  wire logic [TW-1:0]        magnetizing_interval_i,
  input  wire logic [TW-1:0]        brake_release_wait_time_i,
  input  wire logic [TW-1:0]        brake_close_wait_time_i,
  input  wire logic [15:0]          output0_source_select_i,
  input  wire logic [15:0]          output1_source_select_i,
  input  wire logic [15:0]          start_frequency_value_i,
  input  wire logic [15:0]          start_frequency_source_i,
  input  wire logic [15:0]          start_torque_source_i,
  input  wire logic [15:0]          ext_freq_i,
  input  wire logic [15:0]          ext_torque_i,
  // Motor feedback
  input  wire logic [SW-1:0]        speed_rpm_i,
  // Outputs
  output hbs_pkg::hbs_drive_s       drive_o,
  output logic [15:0]               status_word_o,
  output logic [1:0]                dig_out_o,
  output logic [15:0]               start_freq_o,
  output logic [15:0]               start_torque_o
);

  // ********************************************************
  // Control tick
  // ********************************************************
  // Only a bench shortens the tick; the settings then count in those shorter ticks.
  localparam int unsigned TICK_N = TN;
  logic [$clog2(TICK_N)-1:0] div_q;
  logic                      tick_q;

  // Divider makes the 1 ms tick that clocks every interval.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == $bits(div_q)'(TICK_N - 1));
      div_q  <= (div_q == $bits(div_q)'(TICK_N - 1)) ? '0 : div_q + 1'b1;
    end
  end

  // ********************************************************
  // Sequencer
  // ********************************************************
  hbs_pkg::hbs_state_e state_q;
  logic                release_q;
  logic                mag_ld, rel_ld, cls_ld;
  logic                mag_exp, rel_exp, cls_exp;
  logic                seq_en;
  logic                stop_req;
  logic                slow;

  assign seq_en   = (brake_function_enable_i == hbs_pkg::ENABLE_SEQUENCE);
  assign stop_req = stop_i.ramp_stop_cmd | stop_i.quick_stop_cmd;
  assign slow     = (speed_rpm_i < SW'(hbs_pkg::STANDSTILL_RPM));
  assign mag_ld   = (state_q == hbs_pkg::HBS_IDLE) && switch_on_i && !stop_i.coast_stop_cmd;
  // A stop that meets magnetizing expiry must not flash the release command for a cycle.
  assign rel_ld   = (state_q == hbs_pkg::HBS_MAGNETIZE) && mag_exp
                    && !stop_req && !stop_i.coast_stop_cmd;
  assign cls_ld   = (state_q == hbs_pkg::HBS_DECEL) && slow;

  hbs_timer #(.W(TW)) u_mag (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .load_i(mag_ld),
    .value_i(magnetizing_interval_i), .tick_i(tick_q), .expire_o(mag_exp));
  hbs_timer #(.W(TW)) u_rel (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .load_i(rel_ld),
    .value_i(brake_release_wait_time_i), .tick_i(tick_q), .expire_o(rel_exp));
  hbs_timer #(.W(TW)) u_cls (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .load_i(cls_ld),
    .value_i(brake_close_wait_time_i), .tick_i(tick_q), .expire_o(cls_exp));

  // Coast stop has priority over everything: the motor is simply let go.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= hbs_pkg::HBS_IDLE;
    end else if (stop_i.coast_stop_cmd) begin
      state_q <= hbs_pkg::HBS_IDLE;
    end else begin
      case (state_q)
        hbs_pkg::HBS_IDLE: begin
          if (mag_ld) begin
            state_q <= hbs_pkg::HBS_MAGNETIZE;
          end
        end
        hbs_pkg::HBS_MAGNETIZE: begin
          if (stop_req) begin
            state_q <= hbs_pkg::HBS_IDLE;
          end else if (mag_exp) begin
            state_q <= hbs_pkg::HBS_OPENING;
          end
        end
        hbs_pkg::HBS_OPENING: begin
          if (stop_req) begin
            state_q <= hbs_pkg::HBS_DECEL;
          end else if (rel_exp) begin
            state_q <= hbs_pkg::HBS_RUN;
          end
        end
        hbs_pkg::HBS_RUN: begin
          if (stop_req) begin
            state_q <= hbs_pkg::HBS_DECEL;
          end
        end
        hbs_pkg::HBS_DECEL: begin
          if (slow) begin
            state_q <= hbs_pkg::HBS_CLOSING;
          end
        end
        hbs_pkg::HBS_CLOSING: begin
          if (cls_exp) begin
            state_q <= hbs_pkg::HBS_IDLE;
          end
        end
        default: begin
          state_q <= hbs_pkg::HBS_IDLE;
        end
      endcase
    end
  end

  // ********************************************************
  // Brake release command
  // ********************************************************
  // Forced close beats forced release: a closed brake is the safe side.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      release_q <= 1'b0;
    end else if (forced_brake_close_i) begin
      release_q <= 1'b0;
    end else if (forced_brake_release_i) begin
      release_q <= 1'b1;
    end else if (!seq_en || stop_i.coast_stop_cmd) begin
      release_q <= 1'b0;
    end else if (rel_ld) begin
      release_q <= 1'b1;
    end else if (cls_ld || state_q == hbs_pkg::HBS_IDLE
                 || state_q == hbs_pkg::HBS_MAGNETIZE) begin
      release_q <= 1'b0;
    end
  end

  // ********************************************************
  // Registered outputs
  // ********************************************************
  // All outputs are registered: they follow state, release command and settings one cycle later.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drive_o        <= '0;
      status_word_o  <= '0;
      dig_out_o      <= '0;
      start_freq_o   <= hbs_pkg::START_FREQ_DFLT;
      start_torque_o <= '0;
    end else begin
      drive_o.energize     <= (state_q != hbs_pkg::HBS_IDLE);
      drive_o.hold_zero    <= (state_q == hbs_pkg::HBS_MAGNETIZE)
                              || (state_q == hbs_pkg::HBS_OPENING);
      drive_o.ramp_up      <= (state_q == hbs_pkg::HBS_RUN);
      drive_o.decelerate   <= (state_q == hbs_pkg::HBS_DECEL);
      drive_o.slip_comp_on <= (start_frequency_value_i != 16'h0000);
      status_word_o                      <= '0;
      status_word_o[hbs_pkg::STATUS_BIT] <= release_q;
      dig_out_o[0] <= (output0_source_select_i == hbs_pkg::SRC_BRAKE_STATUS) && release_q;
      dig_out_o[1] <= (output1_source_select_i == hbs_pkg::SRC_BRAKE_STATUS) && release_q;
      start_freq_o <= (start_frequency_source_i == hbs_pkg::SRC_START_FREQ)
                      ? start_frequency_value_i : ext_freq_i;
      start_torque_o <= (start_torque_source_i == hbs_pkg::SRC_TORQUE_DFLT)
                        ? 16'h0000 : ext_torque_i;
    end
  end

  chk_coast_drops_release : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    stop_i.coast_stop_cmd && !forced_brake_release_i |=> !release_q)
    else $error("release held after coast stop");
  chk_locked_no_release : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !seq_en && !forced_brake_release_i |=> !release_q)
    else $error("release while brake function locked");
  chk_forced_close : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    forced_brake_close_i |=> !release_q) else $error("forced close ignored");
  chk_forced_release : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    forced_brake_release_i && !forced_brake_close_i |=> release_q)
    else $error("forced release ignored");
  chk_release_after_mag : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    rel_ld && seq_en && !stop_i.coast_stop_cmd && !forced_brake_close_i |=> release_q)
    else $error("release not issued after magnetizing");
  chk_status_bit : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    status_word_o[hbs_pkg::STATUS_BIT] == $past(release_q))
    else $error("status bit does not follow release");
  chk_run_after_wait : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    state_q == hbs_pkg::HBS_OPENING && rel_exp && !stop_req && !stop_i.coast_stop_cmd
    |=> state_q == hbs_pkg::HBS_RUN ##1 drive_o.ramp_up)
    else $error("no ramp after release wait");
  chk_slow_closes : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    state_q == hbs_pkg::HBS_DECEL && slow && !stop_i.coast_stop_cmd
    |=> state_q == hbs_pkg::HBS_CLOSING ##1 drive_o.energize)
    else $error("closing not entered below standstill speed");
  chk_close_deenergize : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    state_q == hbs_pkg::HBS_CLOSING && cls_exp && !stop_i.coast_stop_cmd
    |=> ##1 !drive_o.energize) else $error("motor not de-energized after close wait");
  chk_slip_comp : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    start_frequency_value_i != 16'h0000 |=> drive_o.slip_comp_on)
    else $error("slip compensation not enabled");

endmodule

// ### verification/hbs_brake_model.sv
// Brake and motor stand-in for the holding brake sequencer bench.
// Assumes the release command arrives through one digital output of the sequencer.
`timescale 1ns/1ps
module hbs_brake_model #(
  parameter int unsigned OPEN_CYC  = 400,
  parameter int unsigned CLOSE_CYC = 200
) (
  // Clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                arst_n_i,
  // From the sequencer; the speed setpoint comes from the bench
  input  wire logic                release_cmd_i,
  input  wire hbs_pkg::hbs_drive_s drive_i,
  input  wire logic [15:0]         setpoint_i,
  // To the bench
  output logic                     brake_open_o,
  output logic [15:0]              speed_rpm_o,
  output logic                     load_slip_o
);
  logic [15:0] cnt_q;

  // Relay and armature lag; the sequencer's waits must be longer than these.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q        <= 16'h0000;
      brake_open_o <= 1'b0;
    end else if (release_cmd_i == brake_open_o) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q == 16'(brake_open_o ? CLOSE_CYC : OPEN_CYC)) begin
      cnt_q        <= 16'h0000;
      brake_open_o <= release_cmd_i;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Shaft speed follows the drive; pulling against a shut brake is flagged for good.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      speed_rpm_o <= 16'h0000;
      load_slip_o <= 1'b0;
    end else begin
      if (!drive_i.energize) begin
        speed_rpm_o <= 16'h0000;
      end else if (drive_i.ramp_up && speed_rpm_o < setpoint_i) begin
        speed_rpm_o <= speed_rpm_o + 16'h0001;
      end else if (drive_i.decelerate && speed_rpm_o != 16'h0000) begin
        speed_rpm_o <= speed_rpm_o - 16'h0001;
      end
      if (drive_i.ramp_up && !brake_open_o) begin
        load_slip_o <= 1'b1;
      end
    end
  end
endmodule

// ### verification/hbs_sequencer_tb.sv
// Self-checking bench for the holding brake sequencer with a brake model.
// Assumes the tick divider is shortened to a few cycles, so the 0.1 s waits stay brief.
`timescale 1ns/1ps
module hbs_sequencer_tb;
  logic                sys_clk;
  logic                arst_n;
  logic                sw_on;
  logic                f_rel;
  logic                f_cls;
  logic [1:0]          enable;
  logic [15:0]         o0_sel;
  logic [15:0]         o1_sel;
  logic [15:0]         mag;
  logic [15:0]         f_val;
  logic [15:0]         f_src;
  logic [15:0]         t_src;
  logic [15:0]         speed;
  logic [15:0]         status;
  logic [15:0]         s_freq;
  logic [15:0]         s_torq;
  logic [1:0]          dig_out;
  logic                b_open;
  logic                slip;
  hbs_pkg::hbs_stop_s  stop;
  hbs_pkg::hbs_drive_s drive;
  int                  miscompares;
  int                  checked;
  int                  n;

  // Shortened tick and the expected lengths of both brake waits in cycles.
  localparam int TICK    = 8;
  localparam int REL_CYC = hbs_pkg::RELEASE_WAIT_MS * TICK;
  localparam int CLS_CYC = hbs_pkg::CLOSE_WAIT_MS * TICK;

  // Both waits keep their 0.1 s defaults, which outlast the model's relay and armature lag.
  hbs_sequencer #(.TN(TICK)) i_hbs_sequencer (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
    .switch_on_i(sw_on),
    .stop_i(stop), .forced_brake_release_i(f_rel), .forced_brake_close_i(f_cls),
    .brake_function_enable_i(enable), .magnetizing_interval_i(mag),
    .brake_release_wait_time_i(16'(hbs_pkg::RELEASE_WAIT_MS)),
    .brake_close_wait_time_i(16'(hbs_pkg::CLOSE_WAIT_MS)),
    .output0_source_select_i(o0_sel), .output1_source_select_i(o1_sel),
    .start_frequency_value_i(f_val), .start_frequency_source_i(f_src),
    .start_torque_source_i(t_src), .ext_freq_i(16'h0A5A), .ext_torque_i(16'h0C3C),
    .speed_rpm_i(speed), .drive_o(drive), .status_word_o(status), .dig_out_o(dig_out),
    .start_freq_o(s_freq), .start_torque_o(s_torq));

  hbs_brake_model i_hbs_brake_model (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
    .release_cmd_i(dig_out[0]), .drive_i(drive), .setpoint_i(16'h00C8),
    .brake_open_o(b_open), .speed_rpm_o(speed), .load_slip_o(slip));

  // Compare one value; unknowns never match.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Print counts and the verdict, then stop.
  task automatic end_of_test();
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Outputs are sampled on the falling edge, well clear of the launch edge.
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // The run needs some 4,200 cycles; nearly five times that means something hung.
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    {arst_n, sw_on, stop, f_rel, f_cls, o1_sel, t_src, miscompares, checked} = '0;
    enable = hbs_pkg::ENABLE_SEQUENCE;
    f_val  = 16'h0030;
    f_src  = hbs_pkg::SRC_START_FREQ;
    o0_sel = hbs_pkg::SRC_BRAKE_STATUS;
    // A zero magnetizing interval could release the brake on the first tick after switch-on.
    mag    = 16'h0001;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    // Start value selectors, own source then external sources.
    cyc(3);
    check(s_freq, 16'h0030);
    check(16'(drive.slip_comp_on), 16'h0001);
    check(s_torq, 16'h0000);
    @(posedge sys_clk);
    {f_src, f_val, t_src} <= {16'h0001, 16'h0000, 16'h0001};
    cyc(3);
    check(s_freq, 16'h0A5A);
    check(16'(drive.slip_comp_on), 16'h0000);
    check(s_torq, 16'h0C3C);
    // Forced opening at standstill, then forced closing overriding it.
    @(posedge sys_clk);
    f_rel <= 1'b1;
    cyc(3);
    check(status, 16'h1000);
    check(16'(dig_out), 16'h0001);
    @(posedge sys_clk);
    {o0_sel, o1_sel} <= {16'h0000, hbs_pkg::SRC_BRAKE_STATUS};
    cyc(3);
    check(16'(dig_out), 16'h0002);
    @(posedge sys_clk);
    f_cls <= 1'b1;
    cyc(3);
    check(status, 16'h0000);
    check(16'(dig_out), 16'h0000);
    @(posedge sys_clk);
    {f_rel, f_cls, o0_sel} <= {2'b00, hbs_pkg::SRC_BRAKE_STATUS};
    // Full run: switch-on, open, ramp, quick stop, close.
    sw_on <= 1'b1;
    cyc(3);
    check(16'({drive.energize, drive.hold_zero, status[12]}), 16'h0006);
    @(posedge sys_clk);
    sw_on <= 1'b0;
    for (n = 0; n < 100 && status[12] !== 1'b1; n++) cyc(1);
    check(16'({status[12], dig_out, drive.hold_zero, drive.ramp_up}), 16'h001E);
    for (n = 0; n < 2000 && drive.ramp_up !== 1'b1; n++) cyc(1);
    check(16'(n >= REL_CYC), 16'h0001);
    check(16'(n <= REL_CYC + TICK + 4), 16'h0001);
    check(16'({drive.ramp_up, drive.hold_zero, b_open, slip}), 16'h000A);
    cyc(300);
    @(posedge sys_clk);
    stop.quick_stop_cmd <= 1'b1;
    cyc(3);
    check(16'({drive.decelerate, drive.ramp_up, status[12]}), 16'h0005);
    for (n = 0; n < 1000 && status[12] !== 1'b0; n++) cyc(1);
    check(16'({status[12], drive.energize, speed < 16'h0014, n > 170}), 16'h0007);
    for (n = 0; n < 2000 && drive.energize !== 1'b0; n++) cyc(1);
    check(16'({n >= CLS_CYC, n <= CLS_CYC + TICK + 4, drive.energize, b_open}), 16'h000C);
    // Locked setting: no release, then coast stop ends the run at once.
    @(posedge sys_clk);
    {stop, enable, sw_on} <= {3'b000, hbs_pkg::ENABLE_LOCKED, 1'b1};
    cyc(2000);
    check(16'({drive.energize, status[12]}), 16'h0002);
    @(posedge sys_clk);
    {stop.coast_stop_cmd, sw_on} <= 2'b10;
    cyc(3);
    check(16'({drive.energize, status[12]}), 16'h0000);
    // Sequence setting: coast stop while the brake is commanded open.
    @(posedge sys_clk);
    {stop, enable, sw_on} <= {3'b000, hbs_pkg::ENABLE_SEQUENCE, 1'b1};
    for (n = 0; n < 100 && status[12] !== 1'b1; n++) cyc(1);
    check(16'(status[12]), 16'h0001);
    @(posedge sys_clk);
    {stop.coast_stop_cmd, sw_on} <= 2'b10;
    cyc(3);
    check(16'({status[12], dig_out, drive.energize}), 16'h0000);
    // Ramp stop during the release wait: at standstill the release drops, motor stays on.
    @(posedge sys_clk);
    {stop, sw_on} <= {3'b000, 1'b1};
    for (n = 0; n < 100 && status[12] !== 1'b1; n++) cyc(1);
    @(posedge sys_clk);
    {stop.ramp_stop_cmd, sw_on} <= 2'b10;
    cyc(4);
    check(16'({status[12], drive.energize}), 16'h0001);
    end_of_test();
  end
endmodule
